// >>> src/dso_pkg.sv
// shared constants for the drive status output block
package dso_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int EXC_DELAY_MS = 100;
    localparam int REGEN_HOLD_MS = 100;
    localparam int EXC_DELAY_CYC = (CLK_HZ / 1000) * EXC_DELAY_MS;
    localparam int REGEN_HOLD_CYC = (CLK_HZ / 1000) * REGEN_HOLD_MS;
    localparam int NUM_TERM = 7;
    localparam int SEL_W = 9;
    localparam int FLAG_W = 11;
    localparam int INV_OFFSET = 100;
    // function codes (positive logic)
    localparam logic [8:0] CODE_ACTIVE = 9'h000;
    localparam logic [8:0] CODE_READY = 9'h00B;
    localparam logic [8:0] CODE_FWD = 9'h01E;
    localparam logic [8:0] CODE_REV = 9'h01F;
    localparam logic [8:0] CODE_REGEN = 9'h020;
    localparam logic [8:0] CODE_EXC = 9'h021;
    localparam logic [8:0] CODE_AOS = 9'h02C;
    localparam logic [8:0] CODE_AOS_RAW = 9'h02D;
    localparam logic [8:0] CODE_HARD = 9'h05B;
    localparam logic [8:0] CODE_FAULT = 9'h063;
    localparam logic [8:0] CODE_NONE = 9'h1FF;
    localparam logic [8:0] NUM_CODES_POS = 9'h064;
    localparam logic [8:0] NUM_CODES_ALL = 9'h0C8;
    // APB map
    localparam logic [7:0] ADDR_SEL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_TERM = 8'h24;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // control method field in CTRL[2:0]
    localparam logic [2:0] METHOD_VECTOR = 3'h1;
    localparam int CTRL_TUNE_BIT = 3;
    localparam int CTRL_POSMODE_BIT = 4;
    localparam logic [8:0] SEL_RESET = 9'h1FF;
    // fault flag goes to the relay terminal (index 6) by default
    localparam int RELAY_TERM = 6;
    typedef enum logic [2:0] {
        EXC_IDLE = 3'b001,
        EXC_WAIT = 3'b010,
        EXC_ON = 3'b100
    } dso_exc_state_t;
endpackage : dso_pkg

// >>> src/dso_status_out.sv
// drive status flag generation, terminal routing and APB register file
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - ready flag on whenever the drive can operate, including while running
// - output-active on at or above start frequency; off when stopped, braking, tuning, pre-excited
// - active-or-start on while running or start; forced off on trip or output stop
// - raw active-or-start on while running or start regardless of trip or stop
// - zero-speed pre-excitation sets active-or-start and clears output-active; request-input pre-excitation clears active-or-start
// - excitation-ready on during pre-excitation, even stopped; off at output shutoff
// - request-input excitation-ready after 100 ms, plus tuning time when tuning selected
// - position mode servo-lock by request input turns on active and active-or-start
// - ready off without main power; off in restart coasting on power fail
// - output shutoff clears ready, excitation-ready, active and active-or-start; raw, direction and regen flags are not cleared
// - start with zero frequency command is zero-speed control with listed flags
// - ready routed by code 11, excitation-ready by 33; plus 100 inverts
// - output-active code 0, active-or-start 44, raw 45; inverted 100, 144, 145
// - vector control drives forward or reverse flag from measured direction
// - both direction flags off during pre-excitation in speed or torque mode
// - forward code 30 or 130, reverse code 31 or 131
// - direction flags off outside vector control or when stopped
// - regen flag on in vector control regeneration, held at least 100 ms
// - regen flag off when stopped or pre-excited; code 32 or 132
// - regen flag always off outside vector control
// - fault flag on at any trip; routed to the relay terminal after reset
// - hard-fault flag on for internal circuit faults; code 91 or 191
module dso_status_out #(
    parameter int EXC_DELAY = dso_pkg::EXC_DELAY_CYC,
    parameter int REGEN_HOLD = dso_pkg::REGEN_HOLD_CYC
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic MAIN_POWER_IN,
    input wire logic POWER_FAIL_IN,
    input wire logic RESTART_COAST_IN,
    input wire logic DRIVE_RUNNING_IN,
    input wire logic START_CMD_IN,
    input wire logic FREQ_AT_START_IN,
    input wire logic FREQ_CMD_ZERO_IN,
    input wire logic DC_BRAKE_IN,
    input wire logic TUNING_IN,
    input wire logic TUNING_DONE_IN,
    input wire logic PRE_EXCITATION_REQUEST_IN,
    input wire logic OUTPUT_STOP_INPUT_IN,
    input wire logic PROTECT_TRIP_IN,
    input wire logic HARD_FAULT_IN,
    input wire logic ROTATION_REVERSE_IN,
    input wire logic REGEN_BRAKING_IN,
    output logic [dso_pkg::NUM_TERM-1:0] TERMINAL_OUT,
    output logic [dso_pkg::FLAG_W-1:0] FLAGS_OUT
);
    import dso_pkg::*;

    // three-stage sampling of pins; change accepted when stages 2 and 3 agree
    localparam int NIN = 16;
    logic [NIN-1:0] s1, s2, s3, pin;
    logic [NIN-1:0] raw_pins;
    assign raw_pins = {MAIN_POWER_IN, POWER_FAIL_IN, RESTART_COAST_IN, DRIVE_RUNNING_IN,
                       START_CMD_IN, FREQ_AT_START_IN, FREQ_CMD_ZERO_IN, DC_BRAKE_IN,
                       TUNING_IN, TUNING_DONE_IN, PRE_EXCITATION_REQUEST_IN,
                       OUTPUT_STOP_INPUT_IN, PROTECT_TRIP_IN, HARD_FAULT_IN,
                       ROTATION_REVERSE_IN, REGEN_BRAKING_IN};
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin <= '0;
        end else begin
            s1 <= raw_pins;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < NIN; i++) begin
                if (s2[i] == s3[i]) begin
                    pin[i] <= s3[i];
                end
            end
        end
    end
    logic main_power, power_fail, coast, running, start_cmd, at_start, cmd_zero;
    logic dc_brake, tuning, tune_done, exc_req, out_stop, trip, hard, reverse, regen_in;
    assign {main_power, power_fail, coast, running, start_cmd, at_start, cmd_zero,
            dc_brake, tuning, tune_done, exc_req, out_stop, trip, hard, reverse,
            regen_in} = pin;

    // registers
    logic [SEL_W-1:0] sel [NUM_TERM];
    logic [31:0] ctrl;
    logic [FLAG_W-1:0] flags;
    logic [NUM_TERM-1:0] next_term;
    logic apb_access;
    logic [2:0] addr_idx;
    logic addr_sel_hit;
    assign apb_access = PSEL_IN && PENABLE_IN;
    assign addr_idx = PADDR_IN[4:2];
    assign addr_sel_hit = (PADDR_IN < ADDR_CTRL) && (PADDR_IN[1:0] == 2'b00);

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && (a <= ADDR_TERM);
    endfunction : addr_ok

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < NUM_TERM; i++) begin
                sel[i] <= (i == RELAY_TERM) ? CODE_FAULT : SEL_RESET;
            end
            ctrl <= CTRL_RESET;
        end else if (apb_access && PWRITE_IN && addr_ok(PADDR_IN)) begin
            if (addr_sel_hit) begin
                sel[addr_idx] <= PWDATA_IN[SEL_W-1:0];
            end else if (PADDR_IN == ADDR_CTRL) begin
                ctrl <= {27'h0000000, PWDATA_IN[4:0]};
            end
        end
    end

    // read path; single-cycle access with no wait states
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok(PADDR_IN);
            if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
                if (addr_sel_hit) begin
                    PRDATA_OUT <= {23'h000000, sel[addr_idx]};
                end else if (PADDR_IN == ADDR_CTRL) begin
                    PRDATA_OUT <= ctrl;
                end else if (PADDR_IN == ADDR_STATUS) begin
                    PRDATA_OUT <= {21'h000000, flags};
                end else if (PADDR_IN == ADDR_TERM) begin
                    PRDATA_OUT <= {25'h0000000, TERMINAL_OUT};
                end else begin
                    PRDATA_OUT <= 32'h0000_0000;
                end
            end
        end
    end

    logic vector_mode, tune_sel, pos_mode;
    assign vector_mode = (ctrl[2:0] == METHOD_VECTOR);
    assign tune_sel = ctrl[CTRL_TUNE_BIT];
    assign pos_mode = ctrl[CTRL_POSMODE_BIT];

    // shutoff covers protective trips and the output-stop input
    logic shutoff;
    assign shutoff = trip || out_stop;
    logic zero_speed;
    assign zero_speed = start_cmd && cmd_zero;

    // excitation-ready timing for request-input pre-excitation
    dso_exc_state_t exc_state;
    logic [$clog2(EXC_DELAY+1)-1:0] exc_cnt;
    logic exc_delay_done;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            exc_state <= EXC_IDLE;
            exc_cnt <= '0;
        end else begin
            case (exc_state)
                EXC_IDLE: begin
                    exc_cnt <= '0;
                    if (exc_req && !shutoff) begin
                        exc_state <= EXC_WAIT;
                    end
                end
                EXC_WAIT: begin
                    if (!exc_req || shutoff) begin
                        exc_state <= EXC_IDLE;
                    end else if (exc_cnt < ($clog2(EXC_DELAY+1))'(EXC_DELAY - 1)) begin
                        exc_cnt <= exc_cnt + 1'b1;
                    end else if (!tune_sel || tune_done) begin
                        exc_state <= EXC_ON;
                    end
                end
                EXC_ON: begin
                    if (!exc_req || shutoff) begin
                        exc_state <= EXC_IDLE;
                    end
                end
                default: exc_state <= EXC_IDLE;
            endcase
        end
    end
    assign exc_delay_done = (exc_state == EXC_ON);

    // regeneration hold timer
    logic [$clog2(REGEN_HOLD+1)-1:0] regen_cnt;
    logic regen_allowed;
    assign regen_allowed = vector_mode && running && !exc_req && !zero_speed;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            regen_cnt <= '0;
        end else if (!regen_allowed) begin
            regen_cnt <= '0;
        end else if (regen_in) begin
            regen_cnt <= ($clog2(REGEN_HOLD+1))'(REGEN_HOLD);
        end else if (regen_cnt != '0) begin
            regen_cnt <= regen_cnt - 1'b1;
        end
    end

    // flag bit order: ready, exc, active, aos, aos_raw, fwd, rev, regen, fault, hard, zero
    logic f_ready, f_exc, f_active, f_aos, f_raw, f_fwd, f_rev, f_regen;
    always_comb begin
        f_ready = main_power && !shutoff && !(coast && power_fail);
        f_exc = !shutoff && (exc_delay_done || zero_speed
                || (running && vector_mode));
        f_active = !shutoff && running && at_start && !dc_brake && !tuning
                   && !zero_speed && !exc_req;
        if (pos_mode && exc_req && !shutoff) begin
            f_active = 1'b1;
        end
        f_aos = !shutoff && (running || start_cmd) && !(exc_req && !pos_mode);
        if (pos_mode && exc_req && !shutoff) begin
            f_aos = 1'b1;
        end
        f_raw = running || start_cmd;
        f_fwd = vector_mode && running && !exc_req && !zero_speed && !reverse;
        f_rev = vector_mode && running && !exc_req && !zero_speed && reverse;
        f_regen = regen_allowed && (regen_in || regen_cnt != '0);
    end
    logic [FLAG_W-1:0] next_flags;
    assign next_flags = {zero_speed, hard, trip, f_regen, f_rev, f_fwd, f_raw, f_aos,
                         f_active, f_exc, f_ready};

    // map a function code to a flag value, with optional inversion
    function automatic logic route(input logic [SEL_W-1:0] code,
                                   input logic [FLAG_W-1:0] f);
        logic [SEL_W-1:0] base;
        logic inv;
        logic v;
        inv = (code >= NUM_CODES_POS) && (code < NUM_CODES_ALL);
        base = inv ? code - SEL_W'(INV_OFFSET) : code;
        case (base)
            CODE_READY: v = f[0];
            CODE_EXC: v = f[1];
            CODE_ACTIVE: v = f[2];
            CODE_AOS: v = f[3];
            CODE_AOS_RAW: v = f[4];
            CODE_FWD: v = f[5];
            CODE_REV: v = f[6];
            CODE_REGEN: v = f[7];
            CODE_FAULT: v = f[8];
            CODE_HARD: v = f[9];
            default: v = 1'b0;
        endcase
        // codes 200 and above stay non-conducting regardless of polarity
        if (code >= NUM_CODES_ALL) begin
            route = 1'b0;
        end else begin
            route = v ^ inv;
        end
    endfunction : route

    always_comb begin
        for (int i = 0; i < NUM_TERM; i++) begin
            next_term[i] = route(sel[i], next_flags);
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            flags <= '0;
            TERMINAL_OUT <= '0;
            FLAGS_OUT <= '0;
        end else begin
            flags <= next_flags;
            FLAGS_OUT <= next_flags;
            TERMINAL_OUT <= next_term;
        end
    end
endmodule : dso_status_out

// >>> verif/dso_term_load.sv
// external equipment wired to the drive output terminals
`timescale 1ns/1ps
module dso_term_load (
    input wire logic clk_in,
    input wire logic [6:0] term_in,
    output logic [6:0] seen_out
);
    // contacts latched once a clock; relay bounce is not modelled
    always_ff @(posedge clk_in) begin
        seen_out <= term_in;
    end
endmodule : dso_term_load

// >>> verif/dso_status_out_sva.sv
// assertions on the status output block ports
`timescale 1ns/1ps
module dso_status_out_sva #(
    parameter int EXC_DELAY = 20
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic MAIN_POWER_IN,
    input wire logic DRIVE_RUNNING_IN,
    input wire logic START_CMD_IN,
    input wire logic FREQ_AT_START_IN,
    input wire logic FREQ_CMD_ZERO_IN,
    input wire logic PRE_EXCITATION_REQUEST_IN,
    input wire logic OUTPUT_STOP_INPUT_IN,
    input wire logic PROTECT_TRIP_IN,
    input wire logic HARD_FAULT_IN,
    input wire logic [10:0] FLAGS_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    logic shut;
    int lx_cnt;
    assign shut = PROTECT_TRIP_IN || OUTPUT_STOP_INPUT_IN;
    // saturates so a long request never wraps
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lx_cnt <= 0;
        end else if (!PRE_EXCITATION_REQUEST_IN) begin
            lx_cnt <= 0;
        end else if (lx_cnt < EXC_DELAY + 100) begin
            lx_cnt <= lx_cnt + 1;
        end
    end
    sequence setup_s;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence zero_s;
        (START_CMD_IN && FREQ_CMD_ZERO_IN && MAIN_POWER_IN && !shut && !DRIVE_RUNNING_IN
            && !FREQ_AT_START_IN && !PRE_EXCITATION_REQUEST_IN) [*8];
    endsequence
    apb_ready_a: assert property (setup_s |=> PREADY_OUT) else $error("no zero wait answer");
    ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready too long");
    bad_addr_a: assert property (setup_s ##0 (PADDR_IN > 8'h24) |=> PSLVERR_OUT)
        else $error("bad address accepted");
    fault_on_a: assert property (PROTECT_TRIP_IN [*6] |-> FLAGS_OUT[8]) else $error("fault off");
    hard_fault_a: assert property (HARD_FAULT_IN [*6] |-> FLAGS_OUT[9]) else $error("hard off");
    raw_start_a: assert property (START_CMD_IN [*6] |-> FLAGS_OUT[4]) else $error("raw off");
    shutoff_clear_a: assert property (shut [*6] |-> FLAGS_OUT[3:0] == 4'h0)
        else $error("flags on in shutoff");
    no_power_a: assert property (!MAIN_POWER_IN [*6] |-> !FLAGS_OUT[0]) else $error("ready on");
    zero_speed_a: assert property (zero_s |-> FLAGS_OUT[6:1] == 6'h0D)
        else $error("zero speed flags");
    lx_delay_a: assert property ($rose(FLAGS_OUT[1]) && PRE_EXCITATION_REQUEST_IN
        && !START_CMD_IN && !DRIVE_RUNNING_IN |-> lx_cnt >= EXC_DELAY) else $error("exc early");
endmodule : dso_status_out_sva
bind dso_status_out dso_status_out_sva #(.EXC_DELAY(EXC_DELAY)) dso_status_out_sva_i (.CLK_IN,
    .RST_IN, .PSEL_IN, .PENABLE_IN, .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .MAIN_POWER_IN,
    .DRIVE_RUNNING_IN, .START_CMD_IN, .FREQ_AT_START_IN, .FREQ_CMD_ZERO_IN,
    .PRE_EXCITATION_REQUEST_IN, .OUTPUT_STOP_INPUT_IN, .PROTECT_TRIP_IN, .HARD_FAULT_IN,
    .FLAGS_OUT);

// >>> verif/dso_status_out_tb.sv
// self-checking bench for the status output block
`timescale 1ns/1ps
module dso_status_out_tb;
    import dso_pkg::*;
    localparam int EXC_D = 20;
    localparam logic [15:0] PWR = 16'h0001, PF = 16'h0002, CO = 16'h0004, RUN = 16'h0008;
    localparam logic [15:0] ST = 16'h0010, FAT = 16'h0020, FZ = 16'h0040, LX = 16'h0400;
    localparam logic [15:0] TD = 16'h0200, OST = 16'h0800, TRIP = 16'h1000, HARD = 16'h2000;
    localparam logic [15:0] REV = 16'h4000, RG = 16'h8000;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] pin = 16'h0000;
    logic [6:0] term, seen;
    logic [10:0] flags;
    int bad_count = 0, num_checks = 0;
    dso_status_out #(.EXC_DELAY(EXC_D), .REGEN_HOLD(20)) dso_status_out_i (.CLK_IN(clk),
        .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .MAIN_POWER_IN(pin[0]), .POWER_FAIL_IN(pin[1]), .RESTART_COAST_IN(pin[2]),
        .DRIVE_RUNNING_IN(pin[3]), .START_CMD_IN(pin[4]), .FREQ_AT_START_IN(pin[5]),
        .FREQ_CMD_ZERO_IN(pin[6]), .DC_BRAKE_IN(pin[7]), .TUNING_IN(pin[8]),
        .TUNING_DONE_IN(pin[9]), .PRE_EXCITATION_REQUEST_IN(pin[10]),
        .OUTPUT_STOP_INPUT_IN(pin[11]), .PROTECT_TRIP_IN(pin[12]), .HARD_FAULT_IN(pin[13]),
        .ROTATION_REVERSE_IN(pin[14]), .REGEN_BRAKING_IN(pin[15]), .TERMINAL_OUT(term),
        .FLAGS_OUT(flags));
    dso_term_load dso_term_load_i (.clk_in(clk), .term_in(term), .seen_out(seen));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [8:0] inv(input logic [8:0] c);
        return c + 9'h064;
    endfunction : inv
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // master holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic pins(input logic [15:0] s, input logic [15:0] c, input int n);
        pin <= (pin | s) & ~c;
        repeat (n) @(posedge clk);
    endtask : pins
    task automatic route(input logic [8:0] c [6]);
        for (int i = 0; i < 6; i++) apb(1'b1, 8'(4 * i), 32'(c[i]));
        repeat (8) @(posedge clk);
    endtask : route
    task automatic t_regs();
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q, CTRL_RESET);
        apb(1'b0, ADDR_SEL0 + 8'h18, 32'h0);
        chk(q, 32'(CODE_FAULT));
        apb(1'b0, 8'h28, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h0);
        $display("regs done");
    endtask : t_regs
    task automatic t_idle();
        pins(PWR, 16'h0, 8);
        chk(32'(flags), 32'h001);
        route('{CODE_READY, inv(CODE_READY), inv(CODE_AOS_RAW), CODE_FWD, inv(CODE_REGEN),
            CODE_HARD});
        chk(32'(seen), 32'h15);
        pins(PF | CO, 16'h0, 8);
        chk(32'(flags), 32'h000);
        pins(16'h0, PF | CO | PWR, 8);
        chk(32'(flags), 32'h000);
        pins(PWR, 16'h0, 1);
        $display("idle done");
    endtask : t_idle
    task automatic t_shut();
        pins(RUN | ST | FAT | TRIP, 16'h0, 8);
        chk(32'(flags), 32'h110);
        chk(32'(seen), 32'h52);
        pins(HARD, 16'h0, 8);
        chk(32'(flags), 32'h310);
        pins(OST, TRIP | HARD, 8);
        chk(32'(flags), 32'h010);
        pins(16'h0, OST, 1);
        $display("shutoff done");
    endtask : t_shut
    task automatic t_run();
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        chk(32'(flags), 32'h03F);
        route('{CODE_EXC, CODE_ACTIVE, CODE_AOS, inv(CODE_REV), inv(CODE_AOS), inv(CODE_ACTIVE)});
        chk(32'(seen), 32'h0F);
        pins(REV | RG, 16'h0, 8);
        chk(32'(flags), 32'h0DF);
        pins(16'h0, RG, 12);
        chk(32'(flags), 32'h0DF);
        pins(16'h0, 16'h0, 30);
        chk(32'(flags), 32'h05F);
        apb(1'b1, ADDR_CTRL, 32'h0);
        pins(RG, 16'h0, 8);
        chk(32'(flags[7:5]), 32'h0);
        pins(16'h0, RG | RUN | FAT, 8);
        $display("run done");
    endtask : t_run
    task automatic t_zero();
        apb(1'b1, ADDR_CTRL, 32'h1);
        pins(FZ | RG, 16'h0, 8);
        chk(32'(flags), 32'h41B);
        pins(16'h0, ST | FZ | RG | REV, 8);
        $display("zero speed done");
    endtask : t_zero
    task automatic t_lx();
        pins(LX, 16'h0, 10);
        chk(32'(flags[1]), 32'h0);
        pins(16'h0, 16'h0, EXC_D);
        chk(32'(flags[3:0]), 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h11);
        repeat (8) @(posedge clk);
        chk(32'(flags[3:2]), 32'h3);
        pins(16'h0, LX, 8);
        apb(1'b1, ADDR_CTRL, 32'h9);
        pins(LX, 16'h0, EXC_D + 10);
        chk(32'(flags[1]), 32'h0);
        pins(TD, 16'h0, 8);
        chk(32'(flags[1]), 32'h1);
        $display("pre-excitation done");
    endtask : t_lx
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_idle();
        t_shut();
        t_run();
        t_zero();
        t_lx();
        end_of_test();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule : dso_status_out_tb
